// *** isr_slave_rx.sv ***
/*
 * i2c target, receive path with address and data holding and clock stretching.
 * assumes scl and sda pins are open drain with external pull-ups; both are
 * synchronised into clock_i before any logic looks at them.
 */
// What this block does
// [R1] start sets flag; irq only if enabled
// [R2] address match: irq, release cleared, eighth fall
// [R3] ack timing flag shows irq position
// [R4] reading receive buffer clears buffer full
// [R5] ack slot drives software ack value
// [R6] stretch holds scl low until release set
// [R7] irq after ninth fall on ack only
// [R8] stretch enable stretches after each ack
// [R9] each data byte: irq, release cleared
// [R10] transfer ends on nack or stop flag
// [R11] general call acked when enabled
// [R12] general call raises irq for software
// [R13] ten-bit general call: no update flag
// [R14] unmatched address ignored until next start
`default_nettype none

module isr_slave_rx (
    input wire logic clock_i, // system clock, 50 mhz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic [2:0] addr_i, // register index
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic scl_i, // scl pin level
    output logic scl_o, // scl drive value, always low
    output logic scl_oe_o, // scl pulled low when high
    input wire logic sda_i, // sda pin level
    output logic sda_o, // sda drive value, always low
    output logic sda_oe_o, // sda pulled low when high
    output logic irq_o // level interrupt
);
    // ******************************************************
    // state
    // ******************************************************
    localparam int IRQ_W_L = isr_pkg::IRQ_W;

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_IGNORE} isr_phase_t;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        isr_phase_t phase;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic [7:0] rxbuf;
        logic [7:0] ctrl;
        logic [6:0] own;
        logic bf;
        logic ackt;
        logic start_seen;
        logic stop_seen;
        logic ua;
        logic acked;
        logic stretch;
        logic rose; // an scl rise was seen since the last start
        logic [IRQ_W_L-1:0] irq;
        logic [IRQ_W_L-1:0] mask;
        logic [7:0] rdata;
    } isr_state_t;

    isr_state_t st_r, st_nxt;

    function automatic logic [7:0] ctrl_read(input isr_state_t s);
        ctrl_read = s.ctrl;
    endfunction

    logic scl, sda, scl_fall, scl_rise, start_ev, stop_ev;
    assign scl = st_r.scl_s[1];
    assign sda = st_r.sda_s[1];
    assign scl_fall = st_r.scl_d & ~scl;
    assign scl_rise = ~st_r.scl_d & scl;
    assign start_ev = scl & st_r.scl_d & st_r.sda_d & ~sda;
    assign stop_ev = scl & st_r.scl_d & ~st_r.sda_d & sda;

    // a general call forces the ack; otherwise software's ack value decides, read live
    logic ack_now;
    assign ack_now = st_r.acked | ~st_r.ctrl[isr_pkg::C_ACKV];
    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        logic [7:0] byte_in;
        logic adr_hit, gc_hit;
        byte_in = st_r.shift;
        adr_hit = 1'b0;
        gc_hit = 1'b0;
        st_nxt = st_r;
        st_nxt.scl_s = {st_r.scl_s[0], scl_i};
        st_nxt.sda_s = {st_r.sda_s[0], sda_i};
        st_nxt.scl_d = scl;
        st_nxt.sda_d = sda;
        st_nxt.rdata = isr_pkg::BYTE_ZERO;

        if (scl_rise) begin
            st_nxt.rose = 1'b1;
        end
        if (scl_rise && st_r.bitn <= isr_pkg::BIT_LAST) begin
            st_nxt.shift = {st_r.shift[6:0], sda};
        end
        // the fall that ends a start condition carries no bit, so it is not counted
        if (scl_fall && st_r.rose && st_r.phase inside {ST_ADDR, ST_DATA}) begin
            if (st_r.bitn == isr_pkg::BIT_LAST) begin
                byte_in = st_r.shift;
                adr_hit = byte_in[7:1] == st_r.own; // [R14]
                gc_hit = st_r.phase == ST_ADDR && st_r.ctrl[isr_pkg::C_GC] &&
                    byte_in[7:1] == isr_pkg::GC_ADDR; // [R11]
                st_nxt.bitn = isr_pkg::BIT_ACK;
                if (st_r.phase == ST_ADDR && !(byte_in[0] == 1'b0 && (adr_hit || gc_hit))) begin
                    st_nxt.phase = ST_IGNORE; // [R14]
                end else begin
                    st_nxt.rxbuf = byte_in;
                    st_nxt.bf = 1'b1;
                    st_nxt.ackt = 1'b1; // [R3]
                    st_nxt.irq[isr_pkg::I_PORT] = 1'b1; // [R2] [R9] [R12]
                    st_nxt.ctrl[isr_pkg::C_REL] = 1'b0; // [R2] [R9]
                    st_nxt.stretch = 1'b1;
                    // ten-bit header sets update flag; general call never does
                    if (st_r.phase == ST_ADDR && st_r.ctrl[isr_pkg::C_TEN] && !gc_hit &&
                        byte_in[7:3] == isr_pkg::TEN_HDR) begin
                        st_nxt.ua = 1'b1;
                    end else if (gc_hit) begin
                        st_nxt.ua = 1'b0; // [R13]
                    end
                    // software may still change its ack value while the clock is stretched
                    st_nxt.acked = gc_hit; // [R11]
                    st_nxt.phase = ST_DATA; // [R13]
                end
            end else if (st_r.bitn == isr_pkg::BIT_ACK) begin
                st_nxt.bitn = isr_pkg::BIT_RST;
                st_nxt.ackt = 1'b0;
                if (ack_now) begin
                    st_nxt.irq[isr_pkg::I_PORT] = 1'b1; // [R7]
                    if (st_r.ctrl[isr_pkg::C_STR]) begin
                        st_nxt.stretch = 1'b1; // [R8]
                        st_nxt.ctrl[isr_pkg::C_REL] = 1'b0;
                    end
                end else begin
                    st_nxt.phase = ST_IGNORE; // [R10]
                end
            end else begin
                st_nxt.bitn = st_r.bitn + 4'h1;
            end
        end
        if (st_r.stretch && st_r.ctrl[isr_pkg::C_REL]) begin
            st_nxt.stretch = 1'b0; // [R6]
        end

        if (start_ev) begin
            st_nxt.phase = ST_ADDR;
            st_nxt.bitn = isr_pkg::BIT_RST;
            st_nxt.start_seen = 1'b1; // [R1]
            st_nxt.rose = 1'b0;
            st_nxt.stop_seen = 1'b0;
            st_nxt.stretch = 1'b0;
            if (st_r.ctrl[isr_pkg::C_SIE]) begin
                st_nxt.irq[isr_pkg::I_START] = 1'b1; // [R1]
            end
        end
        if (stop_ev) begin
            st_nxt.phase = ST_IDLE;
            st_nxt.stop_seen = 1'b1; // [R10]
            st_nxt.start_seen = 1'b0;
            st_nxt.stretch = 1'b0;
            if (st_r.ctrl[isr_pkg::C_PIE]) begin
                st_nxt.irq[isr_pkg::I_STOP] = 1'b1;
            end
        end

        if (wr_i) begin
            unique case (addr_i)
                isr_pkg::REG_CTRL: st_nxt.ctrl = wdata_i;
                isr_pkg::REG_IRQ: begin
                    // a new event on a bit not already pending wins over a clear in the same cycle
                    st_nxt.irq = (st_r.irq & ~wdata_i[IRQ_W_L-1:0]) |
                        (st_nxt.irq & ~st_r.irq);
                end
                isr_pkg::REG_MASK: st_nxt.mask = wdata_i[IRQ_W_L-1:0];
                isr_pkg::REG_ADDR: st_nxt.own = wdata_i[7:1];
                default: ;
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                isr_pkg::REG_CTRL: st_nxt.rdata = ctrl_read(st_r);
                isr_pkg::REG_STATUS: begin
                    st_nxt.rdata = {3'h0, st_r.ua, st_r.stop_seen, st_r.start_seen,
                        st_r.ackt, st_r.bf};
                end
                isr_pkg::REG_IRQ: st_nxt.rdata = {5'h00, st_r.irq};
                isr_pkg::REG_MASK: st_nxt.rdata = {5'h00, st_r.mask};
                isr_pkg::REG_ADDR: st_nxt.rdata = {st_r.own, 1'b0};
                isr_pkg::REG_BUF: begin
                    st_nxt.rdata = st_r.rxbuf;
                    // a byte landing this cycle keeps the flag set
                    if (!(st_nxt.bf && !st_r.bf) && st_nxt.rxbuf == st_r.rxbuf) begin
                        st_nxt.bf = 1'b0; // [R4]
                    end
                end
                default: st_nxt.rdata = isr_pkg::BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.scl_s <= 2'h3;
            st_r.sda_s <= 2'h3;
            st_r.scl_d <= 1'b1;
            st_r.sda_d <= 1'b1;
            st_r.ctrl <= isr_pkg::CTRL_RST;
            st_r.own <= isr_pkg::OWN_RST;
            st_r.phase <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ******************************************************
    // outputs
    // ******************************************************
    assign rdata_o = st_r.rdata;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    // held low only after the falling edge, so no runt pulse on scl
    assign scl_oe_o = st_r.stretch & ~scl; // [R6]
    assign sda_oe_o = st_r.phase == ST_DATA && st_r.bitn == isr_pkg::BIT_ACK &&
        ack_now; // [R5]
    assign irq_o = |(st_r.irq & st_r.mask);

    // ******************************************************
    // checks
    // ******************************************************
    property p_start_flag;
        @(posedge clock_i) disable iff (rst_i) start_ev |=> st_r.start_seen;
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("start not flagged"); // [R1]

    property p_addr_irq;
        @(posedge clock_i) disable iff (rst_i)
        scl_fall && st_r.phase == ST_ADDR && st_r.bitn == isr_pkg::BIT_LAST &&
        st_r.shift[7:1] == st_r.own && !st_r.shift[0] && !start_ev && !stop_ev
        |=> st_r.irq[isr_pkg::I_PORT] && st_r.bf;
    endproperty
    a_addr_irq: assert property (p_addr_irq) else $error("address match missed"); // [R2]

    property p_ackt;
        @(posedge clock_i) disable iff (rst_i)
        st_r.ackt |-> st_r.bitn == isr_pkg::BIT_ACK;
    endproperty
    a_ackt: assert property (p_ackt) else $error("ack timing outside ack slot"); // [R3]

    property p_bf_clear;
        @(posedge clock_i) disable iff (rst_i)
        rd_i && addr_i == isr_pkg::REG_BUF && !(scl_fall && st_r.bitn == isr_pkg::BIT_LAST)
        |=> !st_r.bf;
    endproperty
    a_bf_clear: assert property (p_bf_clear) else $error("buffer full not cleared"); // [R4]

    property p_ack_drive;
        @(posedge clock_i) disable iff (rst_i)
        sda_oe_o |-> st_r.bitn == isr_pkg::BIT_ACK &&
        (!st_r.ctrl[isr_pkg::C_ACKV] || st_r.acked);
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack drive wrong"); // [R5]

    property p_release;
        @(posedge clock_i) disable iff (rst_i)
        st_r.ctrl[isr_pkg::C_REL] && !scl_fall && !wr_i |=> !scl_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("scl not released"); // [R6]

    property p_nack_end;
        @(posedge clock_i) disable iff (rst_i)
        scl_fall && st_r.bitn == isr_pkg::BIT_ACK && !ack_now &&
        st_r.phase == ST_DATA && !start_ev && !stop_ev |=> st_r.phase == ST_IGNORE;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("nack did not end"); // [R10]

    property p_ignore;
        @(posedge clock_i) disable iff (rst_i)
        st_r.phase == ST_IGNORE && !start_ev |=> !sda_oe_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("drove bus when ignoring"); // [R14]

    property p_ack_irq;
        @(posedge clock_i) disable iff (rst_i)
        scl_fall && st_r.rose && st_r.phase == ST_DATA && st_r.bitn == isr_pkg::BIT_ACK &&
        ack_now && !start_ev && !stop_ev |=> st_r.irq[isr_pkg::I_PORT];
    endproperty
    a_ack_irq: assert property (p_ack_irq) else $error("no irq after ack"); // [R7]

    property p_stretch_ack;
        @(posedge clock_i) disable iff (rst_i)
        scl_fall && st_r.rose && st_r.phase == ST_DATA && st_r.bitn == isr_pkg::BIT_ACK &&
        ack_now && st_r.ctrl[isr_pkg::C_STR] && !start_ev && !stop_ev |=> st_r.stretch;
    endproperty
    a_stretch_ack: assert property (p_stretch_ack) else $error("no stretch after ack"); // [R8]

    property p_gc_ack;
        @(posedge clock_i) disable iff (rst_i)
        scl_fall && st_r.rose && st_r.phase == ST_ADDR && st_r.bitn == isr_pkg::BIT_LAST &&
        st_r.ctrl[isr_pkg::C_GC] && st_r.shift == isr_pkg::BYTE_ZERO && !start_ev && !stop_ev
        |=> sda_oe_o && st_r.irq[isr_pkg::I_PORT];
    endproperty
    a_gc_ack: assert property (p_gc_ack) else $error("general call not acked"); // [R11] [R12]
endmodule

`default_nettype wire

// *** isr_pkg.sv ***
/*
 * constants for the i2c slave-receive block with address and data holding.
 * assumes a 50 mhz system clock and a register port with one-cycle read latency.
 */
`default_nettype none

package isr_pkg;
    localparam int ADDR_W = 3;
    // register index map
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_IRQ    = 3'h2;
    localparam logic [2:0] REG_MASK   = 3'h3;
    localparam logic [2:0] REG_ADDR   = 3'h4;
    localparam logic [2:0] REG_BUF    = 3'h5;
    // control field positions
    localparam int C_REL = 0;
    localparam int C_ACKV = 1;
    localparam int C_STR = 2;
    localparam int C_GC = 3;
    localparam int C_SIE = 4;
    localparam int C_PIE = 5;
    localparam int C_TEN = 6;
    // status field positions
    localparam int S_BF = 0;
    localparam int S_ACKT = 1;
    localparam int S_START = 2;
    localparam int S_STOP = 3;
    localparam int S_UA = 4;
    // interrupt event positions
    localparam int I_PORT = 0;
    localparam int I_START = 1;
    localparam int I_STOP = 2;
    localparam int IRQ_W = 3;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [6:0] OWN_RST = 7'h00;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_RST = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [4:0] TEN_HDR = 5'h1e;
endpackage

`default_nettype wire

// *** isr_master_model.sv ***
/*
 * behavioural i2c master driving scl and sda as open drain.
 * assumes the bench resolves the wired levels with pull-ups; scl period 260 ns.
 */
`default_nettype none

module isr_master_model (
    input wire logic clock_i, // system clock
    input wire logic scl_i, // scl line level
    input wire logic sda_i, // sda line level
    output logic scl_oe_o, // pull scl low
    output logic sda_oe_o // pull sda low
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // bus phases
    // ********************************
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    task automatic hold();
        repeat (4) @(posedge clock_i);
    endtask
    // the target may stretch, so the line itself is watched, not our own enable
    task automatic scl_up();
        int n;
        n = 0;
        scl_oe_o <= 1'b0;
        @(posedge clock_i);
        while (scl_i !== 1'b1 && n < 5000) begin
            @(posedge clock_i);
            n++;
        end
        hold();
    endtask
    task automatic start_c();
        sda_oe_o <= 1'b0;
        hold();
        scl_up();
        sda_oe_o <= 1'b1;
        hold();
        scl_oe_o <= 1'b1;
        hold();
    endtask
    task automatic stop_c();
        sda_oe_o <= 1'b1;
        hold();
        scl_up();
        sda_oe_o <= 1'b0;
        hold();
    endtask
    // sda only moves while scl is low, so no false start or stop is made
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_oe_o <= ~b[i];
            hold();
            scl_up();
            scl_oe_o <= 1'b1;
            hold();
        end
        sda_oe_o <= 1'b0;
        hold();
        scl_up();
        ack = sda_i;
        scl_oe_o <= 1'b1;
        hold();
    endtask
endmodule

`default_nettype wire

// *** testbench.sv ***
/*
 * self-checking bench for isr_slave_rx with a master model on the pins.
 * assumes pull-ups on scl and sda, modelled by the wired levels below.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_p = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic [6:0] own;
    logic [7:0] dat;
    logic [15:0] note;
    logic scl_oe_o, sda_oe_o, irq_o, m_scl_oe, m_sda_oe, ack;
    wire logic scl = ~(scl_oe_o | m_scl_oe);
    wire logic sda = ~(sda_oe_o | m_sda_oe);
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [15:0] exp_q[$];
    string nam_q[$];
    always #10 clock_i = ~clock_i;
    isr_slave_rx i_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
    isr_master_model i_mst (.clock_i(clock_i), .scl_i(scl), .sda_i(sda),
        .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
    // ********************************
    // checks and bus tasks
    // ********************************
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // the note is taken at the strobe, the data come back one cycle later
    task automatic rd(logic [2:0] a, logic [7:0] e, logic [7:0] m, string nm);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back({m, e});
        nam_q.push_back(nm);
        @(posedge clock_i);
        rd_i <= 1'b0;
    endtask
    always @(posedge clock_i) rd_p <= rd_i;
    always @(negedge clock_i) begin
        if (rd_p) begin
            note = exp_q.pop_front();
            chk(nam_q.pop_front(), note[7:0], rdata_o & note[15:8]);
        end
    end
    task automatic wait_irq();
        int n;
        n = 0;
        // let a clear written on the previous edge settle before looking
        @(posedge clock_i);
        while (irq_o !== 1'b1 && n < 3000) begin
            @(posedge clock_i);
            n++;
        end
        chk("irq_o", 8'h01, {7'h00, irq_o});
    endtask
    // one byte from the master while software services the stretch points
    task automatic xfer(logic [7:0] b, logic [7:0] c, logic ea, logic i9);
        fork
            i_mst.send_byte(b, ack);
            begin
                wait_irq();
                chk("stretch", 8'h01, {7'h00, scl_oe_o});
                rd(isr_pkg::REG_BUF, b, 8'hff, "buffer");
                rd(isr_pkg::REG_STATUS, 8'h02, 8'h03, "full and ack time");
                wr(isr_pkg::REG_IRQ, 8'h01);
                wr(isr_pkg::REG_CTRL, c);
                if (i9) begin
                    wait_irq();
                    chk("stretch after ack", 8'h01, {7'h00, scl_oe_o});
                    rd(isr_pkg::REG_STATUS, 8'h00, 8'h02, "ack time");
                    wr(isr_pkg::REG_IRQ, 8'h01);
                    wr(isr_pkg::REG_CTRL, c);
                end
            end
        join
        chk("ack", {7'h00, ea}, {7'h00, ack});
    endtask
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            summarize();
        end
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        void'($urandom(32'hcb1b));
        own = 7'($urandom_range(1, 126));
        dat = 8'($urandom);
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(isr_pkg::REG_CTRL, 8'h01, 8'hff, "ctrl");
        rd(isr_pkg::REG_STATUS, 8'h00, 8'hff, "status");
        rd(isr_pkg::REG_IRQ, 8'h00, 8'hff, "irq");
        rd(isr_pkg::REG_MASK, 8'h00, 8'hff, "mask");
        rd(3'h7, 8'h00, 8'hff, "unmapped");
        $display("test reset values done");
        wr(isr_pkg::REG_MASK, 8'h07);
        wr(isr_pkg::REG_ADDR, {own, 1'b0});
        wr(isr_pkg::REG_CTRL, 8'h15);
        i_mst.start_c();
        rd(isr_pkg::REG_STATUS, 8'h04, 8'h04, "start seen");
        rd(isr_pkg::REG_IRQ, 8'h02, 8'hff, "start irq");
        wr(isr_pkg::REG_IRQ, 8'h02);
        xfer({own, 1'b0}, 8'h15, 1'b0, 1'b1);
        xfer(dat, 8'h15, 1'b0, 1'b1);
        xfer(~dat, 8'h17, 1'b1, 1'b0);
        rd(isr_pkg::REG_IRQ, 8'h00, 8'hff, "no irq after nack");
        i_mst.stop_c();
        rd(isr_pkg::REG_STATUS, 8'h08, 8'h08, "stop seen");
        rd(isr_pkg::REG_IRQ, 8'h00, 8'hff, "stop irq off");
        $display("test address and data done");
        wr(isr_pkg::REG_CTRL, 8'h4d);
        i_mst.start_c();
        xfer(8'h00, 8'h4d, 1'b0, 1'b1);
        rd(isr_pkg::REG_STATUS, 8'h00, 8'h10, "update address");
        xfer(dat, 8'h4d, 1'b0, 1'b1);
        wr(isr_pkg::REG_CTRL, 8'h0d);
        i_mst.start_c();
        i_mst.send_byte({~own, 1'b0}, ack);
        chk("foreign ack", 8'h01, {7'h00, ack});
        rd(isr_pkg::REG_IRQ, 8'h00, 8'hff, "foreign irq");
        i_mst.stop_c();
        $display("test general call and foreign address done");
        repeat (4) @(posedge clock_i);
        summarize();
    end
endmodule

`default_nettype wire
